// file: rtl/pagpio_port_a.sv
`timescale 1ns/1ns
`include "pagpio_map.svh"
// Operation
// - Eight-bit port, bit four has no pin
// - Direction one disables driver, zero enables
// - Input-only pin direction always reads one
// - Data read returns pins, write hits latch
// - Data write stores written bits, or pins if strobe clear
// - Analog-selected pins read as zero
// - Direction gates drivers even on analog pins
// - Digital outputs drive only with direction clear
// - Enabled peripheral owns its pin
// - Analog select disables digital input buffer
// - Per-pin change enables, cleared at reset
// - Pull-ups only on bits three-zero, five
// - Pull-ups on bits three-zero have software enable bits
// - Pull-up off for output, alternate, global disable
// - Reset pin pull-up follows fuse only
// - Analog select resets to analog mode
// - Highest-priority output function wins pin
// - Pin seven only pulls low
module pagpio_port_a
  import pagpio_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pagpio_pkg::pagpio_addr_t paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pins
  input wire pagpio_pkg::pagpio_byte_t pin_in,
  output pagpio_pkg::pagpio_byte_t pin_out,
  output pagpio_pkg::pagpio_byte_t pin_oe,
  output pagpio_pkg::pagpio_byte_t pull_up_on,
  // Alternate functions, low to high priority
  input wire pagpio_pkg::pagpio_byte_t alt_lo_en,
  input wire pagpio_pkg::pagpio_byte_t alt_lo_out,
  input wire pagpio_pkg::pagpio_byte_t alt_hi_en,
  input wire pagpio_pkg::pagpio_byte_t alt_hi_out,
  // Configuration fuses
  input wire pagpio_pkg::pagpio_byte_t fuse_word,
  // Interrupt
  output logic irq
);
  import pagpio_pkg::*;

  // ----------------------------------------
  // Registers and synchronisers
  // ----------------------------------------
  pagpio_byte_t pin_direction_reg;
  pagpio_byte_t port_latch;
  pagpio_byte_t analog_select;
  pagpio_byte_t pull_up_enable;
  pagpio_byte_t change_irq_enable;
  logic pull_up_global_disable;
  pagpio_byte_t irq_status;
  pagpio_byte_t irq_mask;
  pagpio_byte_t pin_meta;
  pagpio_byte_t pin_sync;
  pagpio_byte_t pin_prev;
  pagpio_byte_t fuse_meta;
  pagpio_byte_t fuse_sync;
  logic prev_valid;

  // ----------------------------------------
  // Combinational views
  // ----------------------------------------
  pagpio_byte_t dig_in;
  pagpio_byte_t dir_view;
  pagpio_byte_t alt_en;
  pagpio_byte_t next_drive_val;
  pagpio_byte_t next_drive_en;
  pagpio_byte_t next_oe;
  pagpio_byte_t next_out;
  pagpio_byte_t next_pull;
  pagpio_byte_t change_evt;
  logic [31:0] next_prdata;
  pagpio_sel_t sel;
  logic setup;
  logic access;
  logic wr_done;
  logic rd_done;
  logic reset_pin_sel;

  // Strobes use the registered ready, so each transfer acts once
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr_done = access & pwrite & pstrb[0];
  assign rd_done = access & ~pwrite;
  assign reset_pin_sel = fuse_sync[`PAGPIO_FUSE_RESET_SEL];

  // Pins pass two flops before anything reads them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Fuses are static, but arrive from outside this clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_meta <= 8'h00;
      fuse_sync <= 8'h00;
    end else begin
      fuse_meta <= fuse_word;
      fuse_sync <= fuse_meta;
    end
  end

  // Digital input buffer off on analog pins and absent bit
  assign dig_in = pin_sync & ~analog_select & `PAGPIO_PIN_MASK;

  always_comb begin
    dir_view = pin_direction_reg & `PAGPIO_PIN_MASK;
    dir_view[`PAGPIO_BIT_INPUT_ONLY] = 1'b1;
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Full decode: aliases of a register answer as unmapped
  always_comb begin
    case (paddr)
      `PAGPIO_OFF_DIR: sel = PAGPIO_SEL_DIR;
      `PAGPIO_OFF_DATA: sel = PAGPIO_SEL_DATA;
      `PAGPIO_OFF_ANSEL: sel = PAGPIO_SEL_ANSEL;
      `PAGPIO_OFF_PULL: sel = PAGPIO_SEL_PULL;
      `PAGPIO_OFF_IOC: sel = PAGPIO_SEL_IOC;
      `PAGPIO_OFF_CTRL: sel = PAGPIO_SEL_CTRL;
      `PAGPIO_OFF_STAT: sel = PAGPIO_SEL_STAT;
      `PAGPIO_OFF_MASK: sel = PAGPIO_SEL_MASK;
      default: sel = PAGPIO_SEL_NONE;
    endcase
  end

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  // Zero-wait slave: ready rises in the access cycle, one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // Unmapped offsets answer with an error and change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup & (sel == PAGPIO_SEL_NONE);
    end
  end

  // Zero outside a read, so the bus never shows a stale value
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (sel)
        PAGPIO_SEL_DIR: next_prdata = {24'h000000, dir_view};
        PAGPIO_SEL_DATA: next_prdata = {24'h000000, dig_in};
        PAGPIO_SEL_ANSEL: next_prdata = {24'h000000, analog_select};
        PAGPIO_SEL_PULL: next_prdata = {24'h000000, pull_up_enable};
        PAGPIO_SEL_IOC: next_prdata = {24'h000000, change_irq_enable};
        PAGPIO_SEL_CTRL: next_prdata = {31'h00000000, pull_up_global_disable};
        PAGPIO_SEL_STAT: next_prdata = {24'h000000, irq_status};
        PAGPIO_SEL_MASK: next_prdata = {24'h000000, irq_mask};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // Writes set bit four; the pin mask keeps its driver off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_reg <= `PAGPIO_RST_DIR;
    end else if (wr_done && sel == PAGPIO_SEL_DIR) begin
      pin_direction_reg <= pwdata[7:0] | ~`PAGPIO_PIN_MASK;
    end
  end

  // A write without pstrb[0] stores the pins, so untouched outputs
  // can flip to what the pin shows; analog pins store zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_latch <= 8'h00;
    end else if (access && pwrite && sel == PAGPIO_SEL_DATA) begin
      if (pstrb[0]) begin
        port_latch <= pwdata[7:0] & `PAGPIO_PIN_MASK;
      end else begin
        port_latch <= dig_in;
      end
    end
  end

  // Only the four analog-capable pins can leave digital mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_select <= `PAGPIO_RST_ANSEL;
    end else if (wr_done && sel == PAGPIO_SEL_ANSEL) begin
      analog_select <= pwdata[7:0] & `PAGPIO_ANSEL_MASK;
    end
  end

  // Pins without a switchable pull-up store nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_up_enable <= `PAGPIO_RST_PULL;
    end else if (wr_done && sel == PAGPIO_SEL_PULL) begin
      pull_up_enable <= pwdata[7:0] & `PAGPIO_PU_SW_MASK;
    end
  end

  // Change enables start cleared so reset raises no event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_irq_enable <= `PAGPIO_RST_IOC;
    end else if (wr_done && sel == PAGPIO_SEL_IOC) begin
      change_irq_enable <= pwdata[7:0] & `PAGPIO_PIN_MASK;
    end
  end

  // Global disable comes up set, so switchable pull-ups start off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_up_global_disable <= 1'(`PAGPIO_RST_CTRL);
    end else if (wr_done && sel == PAGPIO_SEL_CTRL) begin
      pull_up_global_disable <= pwdata[`PAGPIO_CTRL_PU_GDIS];
    end
  end

  // Mask starts clear: no interrupt until software asks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `PAGPIO_RST_MASK;
    end else if (wr_done && sel == PAGPIO_SEL_MASK) begin
      irq_mask <= pwdata[7:0] & `PAGPIO_PIN_MASK;
    end
  end

  // ----------------------------------------
  // Change detection and interrupt
  // ----------------------------------------
  // First compare waits one cycle, but the synchroniser takes two, so a pin high at reset still looks like an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= 8'h00;
    end else begin
      pin_prev <= dig_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_valid <= 1'b0;
    end else begin
      prev_valid <= 1'b1;
    end
  end

  assign change_evt = prev_valid ? ((dig_in ^ pin_prev) & change_irq_enable) : 8'h00;

  // Read clears, but an edge in the same cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 8'h00;
    end else if (rd_done && sel == PAGPIO_SEL_STAT) begin
      irq_status <= change_evt;
    end else begin
      irq_status <= irq_status | change_evt;
    end
  end

  // Registered output; the price is one cycle of lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------
  // Output priority and drivers
  // ----------------------------------------
  assign alt_en = alt_lo_en | alt_hi_en;

  // An enabled peripheral outranks the latch; high outranks low
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (alt_hi_en[i]) begin
        next_drive_val[i] = alt_hi_out[i];
      end else if (alt_lo_en[i]) begin
        next_drive_val[i] = alt_lo_out[i];
      end else begin
        next_drive_val[i] = port_latch[i];
      end
    end
  end

  // Direction alone gates drivers, analog mode or not
  always_comb begin
    next_drive_en = ~dir_view & `PAGPIO_PIN_MASK;
    next_out = next_drive_val & next_drive_en;
    next_oe = next_drive_en;
    // Open drain: only ever pulls low
    next_out[`PAGPIO_BIT_OPEN_DRAIN] = 1'b0;
    next_oe[`PAGPIO_BIT_OPEN_DRAIN] = next_drive_en[`PAGPIO_BIT_OPEN_DRAIN]
      & ~next_drive_val[`PAGPIO_BIT_OPEN_DRAIN];
  end

  // ----------------------------------------
  // Weak pull-ups
  // ----------------------------------------
  // Reset-pin pull-up ignores software, the global disable included
  always_comb begin
    next_pull = pull_up_enable & `PAGPIO_PU_SW_MASK & dir_view & ~alt_en;
    if (pull_up_global_disable) begin
      next_pull = 8'h00;
    end
    next_pull[`PAGPIO_BIT_INPUT_ONLY] = reset_pin_sel;
    next_pull[`PAGPIO_BIT_ABSENT] = 1'b0;
  end

  // Pads change only on a clock edge, never straight from the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 8'h00;
    end else begin
      pin_out <= next_out;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe <= 8'h00;
    end else begin
      pin_oe <= next_oe;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_up_on <= 8'h00;
    end else begin
      pull_up_on <= next_pull;
    end
  end
endmodule

// file: inc/pagpio_map.svh
`ifndef PAGPIO_MAP_SVH
`define PAGPIO_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PAGPIO_OFF_DIR 12'h000
`define PAGPIO_OFF_DATA 12'h004
`define PAGPIO_OFF_ANSEL 12'h008
`define PAGPIO_OFF_PULL 12'h00C
`define PAGPIO_OFF_IOC 12'h010
`define PAGPIO_OFF_CTRL 12'h014
`define PAGPIO_OFF_STAT 12'h018
`define PAGPIO_OFF_MASK 12'h01C

// ----------------------------------------
// Pin set and field positions
// ----------------------------------------
`define PAGPIO_PIN_MASK 8'hEF
`define PAGPIO_PU_SW_MASK 8'h0F
`define PAGPIO_ANSEL_MASK 8'h0F
`define PAGPIO_BIT_INPUT_ONLY 5
`define PAGPIO_BIT_OPEN_DRAIN 7
`define PAGPIO_BIT_ABSENT 4
`define PAGPIO_FUSE_RESET_SEL 5
`define PAGPIO_CTRL_PU_GDIS 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PAGPIO_RST_DIR 8'hEF
`define PAGPIO_RST_ANSEL 8'h0F
`define PAGPIO_RST_PULL 8'h00
`define PAGPIO_RST_IOC 8'h00
`define PAGPIO_RST_CTRL 8'h01
`define PAGPIO_RST_MASK 8'h00

`endif

// file: inc/pagpio_pkg.sv
package pagpio_pkg;
  typedef logic [7:0] pagpio_byte_t;
  typedef logic [11:0] pagpio_addr_t;
  typedef enum logic [3:0] {
    PAGPIO_SEL_DIR,
    PAGPIO_SEL_DATA,
    PAGPIO_SEL_ANSEL,
    PAGPIO_SEL_PULL,
    PAGPIO_SEL_IOC,
    PAGPIO_SEL_CTRL,
    PAGPIO_SEL_STAT,
    PAGPIO_SEL_MASK,
    PAGPIO_SEL_NONE
  } pagpio_sel_t;
endpackage

// file: test/pagpio_board.sv
`timescale 1ns/1ns
module pagpio_board
  import pagpio_pkg::*;
(
  // Device side
  input wire logic pclk,
  input wire pagpio_pkg::pagpio_byte_t pin_out,
  input wire pagpio_pkg::pagpio_byte_t pin_oe,
  input wire pagpio_pkg::pagpio_byte_t pull_up_on,
  // Board drive
  input wire pagpio_pkg::pagpio_byte_t ext_val,
  input wire pagpio_pkg::pagpio_byte_t ext_en,
  output pagpio_pkg::pagpio_byte_t pin_in
);
  logic wobble = 1'h0;
  always_ff @(posedge pclk) begin
    wobble <= ~wobble;
  end
  // Floating pins wander, so a stale level never reads back
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pull_up_on[i]) pin_in[i] = 1'h1;
      else pin_in[i] = wobble ^ i[0];
    end
  end
endmodule

// file: test/pagpio_port_a_props.sv
`timescale 1ns/1ns
`include "pagpio_map.svh"
module pagpio_port_a_props
  import pagpio_pkg::*;
(
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pagpio_pkg::pagpio_addr_t paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pins and interrupt
  input wire pagpio_pkg::pagpio_byte_t pin_out,
  input wire pagpio_pkg::pagpio_byte_t pin_oe,
  input wire pagpio_pkg::pagpio_byte_t pull_up_on,
  input wire pagpio_pkg::pagpio_byte_t fuse_word,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_at(pagpio_addr_t a);
    pready && !pwrite && paddr == a;
  endsequence
  sequence dir_wr;
    psel && penable && pready && pwrite && pstrb[0] && paddr == `PAGPIO_OFF_DIR;
  endsequence
  sequence fuse_held;
    $stable(fuse_word[5]) [*5];
  endsequence
  rdy_after_setup_a:
    assert property (psel && !penable |=> pready) else $error("no ready after setup");
  dir_oe_a:
    assert property (dir_wr |=> ##1 pin_oe[3:0] == ~$past(pwdata[3:0], 2))
    else $error("drive enable does not follow direction");
  dir_five_a:
    assert property (rd_at(`PAGPIO_OFF_DIR) |-> prdata[5] && !prdata[4])
    else $error("direction read bit five or four wrong");
  no_pin4_a:
    assert property (!pin_oe[4] && !pin_oe[5] && !pull_up_on[4]) else $error("bit four active");
  od_pin_a:
    assert property (!pin_out[7]) else $error("pin seven driven high");
  pull_set_a:
    assert property (pull_up_on[7:6] == 2'h0) else $error("pull-up on bit six or seven");
  pull_out_a:
    assert property ((pin_oe[3:0] & pull_up_on[3:0]) == 4'h0) else $error("pull-up on output");
  fuse_pull_a:
    assert property (fuse_held |-> pull_up_on[5] == fuse_word[5]) else $error("pin five pull-up");
  irq_stat_a:
    assert property (rd_at(`PAGPIO_OFF_STAT) && irq && !$past(pready) |-> prdata[7:0] != 8'h0)
    else $error("irq high with empty status");
endmodule
bind pagpio_port_a pagpio_port_a_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_on(pull_up_on),
  .fuse_word(fuse_word), .irq(irq));

// file: test/testbench.sv
`timescale 1ns/1ns
`include "pagpio_map.svh"
module testbench;
  import pagpio_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  pagpio_addr_t paddr;
  pagpio_byte_t pin_in, pin_out, pin_oe, pull_up_on, alt_lo_en, alt_lo_out;
  pagpio_byte_t alt_hi_en, alt_hi_out, fuse_word, ext_val, ext_en, r;
  logic [32:0] exp_q[$];
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  integer seed;
  pagpio_port_a dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_on(pull_up_on), .alt_lo_en(alt_lo_en), .alt_lo_out(alt_lo_out),
    .alt_hi_en(alt_hi_en), .alt_hi_out(alt_hi_out), .fuse_word(fuse_word), .irq(irq));
  pagpio_board board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_on(pull_up_on), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  task chk(input string n, input logic [32:0] s, input logic [32:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // A read notes {pslverr, prdata} for the monitor
  task apb(input logic w, input pagpio_addr_t a, input logic [32:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d[31:0];
    if (!w) exp_q.push_back(d);
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  always @(posedge pclk) begin
    if (pready && !pwrite && exp_q.size() > 0) chk("read", {pslverr, prdata}, exp_q.pop_front());
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      results;
    end
  end
  initial begin
    seed = 32'h4E8F;
    {presetn, psel, penable, pwrite, paddr, pwdata, fuse_word} = '0;
    {alt_lo_en, alt_lo_out, alt_hi_en, alt_hi_out} = '0;
    {pstrb, ext_en, ext_val} = {4'hF, 8'hA0, 8'hA0};
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `PAGPIO_OFF_DIR, 33'h0EF);
    apb(1'h0, `PAGPIO_OFF_ANSEL, 33'h00F);
    apb(1'h0, `PAGPIO_OFF_IOC, 33'h000);
    apb(1'h0, `PAGPIO_OFF_CTRL, 33'h001);
    apb(1'h0, 12'h020, 33'h100000000);
    r = 8'($random(seed)) | 8'h80;
    apb(1'h1, `PAGPIO_OFF_DIR, 33'h0);
    apb(1'h1, `PAGPIO_OFF_DATA, {25'h0, r});
    repeat (4) @(posedge pclk);
    chk("oe", pin_oe, 8'h4F);
    chk("out", pin_out & 8'h4F, r & 8'h4F);
    apb(1'h0, `PAGPIO_OFF_DATA, {25'h0, r[7:6], 6'h20});
    apb(1'h1, `PAGPIO_OFF_ANSEL, 33'h0);
    apb(1'h0, `PAGPIO_OFF_DATA, {25'h0, r[7:6], 2'h2, r[3:0]});
    ext_val[7] <= 1'h0;
    pstrb <= 4'h0;
    repeat (3) @(posedge pclk);
    apb(1'h1, `PAGPIO_OFF_DATA, 33'h0);
    pstrb <= 4'hF;
    ext_val[7] <= 1'h1;
    repeat (3) @(posedge pclk);
    chk("rmw", pin_oe, 8'hCF);
    {alt_lo_en, alt_lo_out, alt_hi_en, alt_hi_out} <= {8'h03, ~r, 8'h01, r};
    repeat (3) @(posedge pclk);
    chk("prio", pin_out[1:0], {~r[1], r[0]});
    apb(1'h1, `PAGPIO_OFF_CTRL, 33'h0);
    apb(1'h1, `PAGPIO_OFF_PULL, 33'h0FF);
    apb(1'h0, `PAGPIO_OFF_PULL, 33'h00F);
    chk("pull out", pull_up_on, 8'h00);
    apb(1'h1, `PAGPIO_OFF_DIR, 33'h0FF);
    repeat (3) @(posedge pclk);
    chk("pull in", pull_up_on, 8'h0C);
    apb(1'h1, `PAGPIO_OFF_CTRL, 33'h001);
    fuse_word <= 8'h20;
    repeat (6) @(posedge pclk);
    chk("pull gdis", pull_up_on, 8'h20);
    apb(1'h1, `PAGPIO_OFF_IOC, 33'h020);
    apb(1'h1, `PAGPIO_OFF_MASK, 33'h020);
    ext_val[5] <= 1'h0;
    repeat (10) if (!irq) @(posedge pclk);
    chk("irq", irq, 1'h1);
    apb(1'h0, `PAGPIO_OFF_STAT, 33'h020);
    repeat (3) @(posedge pclk);
    chk("irq clr", irq, 1'h0);
    apb(1'h1, `PAGPIO_OFF_MASK, 33'h0);
    ext_val[5] <= 1'h1;
    repeat (6) @(posedge pclk);
    chk("irq mask", irq, 1'h0);
    apb(1'h0, `PAGPIO_OFF_STAT, 33'h020);
    repeat (2) @(posedge pclk);
    results;
  end
endmodule
